// ---- core/ubg_defs.svh ----
// Overview of operation
// [RULE_01] Reference clock: doubled prescaled clock over divider+1
// [RULE_02] Host never programs fire divider zero
// [RULE_03] Each pulse spans two reference periods
// [RULE_04] Emit programmed count, 1 to 127
// [RULE_05] Count zero keeps generator off
// [RULE_06] Up to 15 pulses: per-pulse phase bit
// [RULE_07] Phase bits applied LSB first
// [RULE_08] Burst starts only on start-cycle opcode
// [RULE_09] Fire-as-start routes burst to converter start
// [RULE_10] Idle level: high-Z or ground
// [RULE_11] Driver bits: invert down, enable up, down
// [RULE_12] Repetition field sets 0 to 7 repeats
// [RULE_13] Sequence end after 5 us silence
// [RULE_14] Sing-around forwards fire input without delay; code forwards it 4 cycles late
// [RULE_15] Phase noise on unless disabled
// [RULE_16] Fast init on interrupt rise, mode 1
// [RULE_17] Start jitter adds random start offset
// [RULE_18] Host keeps start enabled during calibration
// [RULE_19] Host shares one calibration per pair
// [RULE_20] Calibration result 16.16 fixed point
// [RULE_21] Outputs return to idle level after burst
`ifndef UBG_DEFS_SVH
`define UBG_DEFS_SVH
`define UBG_CLK_MHZ         100
`define UBG_QUIET_NS        5000
`define UBG_QUIET_CYCLES    ((`UBG_QUIET_NS * `UBG_CLK_MHZ) / 1000)
`define UBG_PHASE_MAX_PULSE 7'h0f
`define UBG_CFG_INVDOWN     2
`define UBG_CFG_ENUP        1
`define UBG_CFG_ENDOWN      0
`define UBG_LFSR_SEED       8'ha5
`endif

// ---- core/ubg_pkg.sv ----
package ubg_pkg;
  typedef enum logic [1:0] {UBG_IDLE, UBG_FIRST, UBG_SECOND, UBG_WAIT} ubg_state_t;
  typedef logic [6:0]  ubg_count_t;
  typedef logic [31:0] ubg_fix_t;
endpackage : ubg_pkg

// ---- core/ubg_refclk.sv ----
`timescale 1ns/1ns
`include "ubg_defs.svh"
// Reference tick: one per (div+1)/2 prescaled periods, i.e. doubled then divided
module ubg_refclk (
  input  wire logic       mclk,       // System clock
  input  wire logic       reset_n,    // Async reset
  input  wire logic       clk_en,     // Clock enable
  input  wire logic       fast_tick,  // Prescaled clock tick
  input  wire logic       run,        // Divider running
  input  wire logic [3:0] fire_div,   // Fire divider field
  output logic            ref_tick    // Reference clock tick
);
  logic [4:0] acc;
  logic [4:0] sum;
  assign sum = acc + 5'h02;
  // Add two per prescaled tick: frequency doubled, then divide by div+1
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc      <= 5'h00;
      ref_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      ref_tick <= 1'b0;
      if (!run)
        acc <= 5'h00;
      else if (fast_tick)
      begin
        if (sum > {1'b0, fire_div}) // RULE_01
        begin
          acc      <= sum - {1'b0, fire_div} - 5'h01;
          ref_tick <= 1'b1;
        end
        else
          acc <= sum;
      end
    end
  end
endmodule : ubg_refclk

// ---- core/ubg_core.sv ----
`timescale 1ns/1ns
`include "ubg_defs.svh"
module ubg_core (
  input  wire logic               mclk,              // 100 MHz clock
  input  wire logic               reset_n,           // Async reset, active low
  input  wire logic               clk_en,            // Freezes state while low
  input  wire logic               fast_clock_prescale, // Tick of prescaled oscillator
  input  wire logic               start_cycle,       // Start-cycle opcode pulse
  input  wire ubg_pkg::ubg_count_t pulse_count,      // Pulses per burst
  input  wire logic [3:0]         fire_div,          // Fire divider (not 0)
  input  wire logic [15:0]        pulse_phase_bits,  // Per-pulse phase
  input  wire logic [2:0]         driver_config,     // Invert/up/down enables
  input  wire logic               idle_level_select, // 0 high-Z, 1 ground
  input  wire logic               fire_as_start,     // Route burst to start
  input  wire logic [2:0]         repeat_count,      // Burst repetitions
  input  wire logic               phase_noise_off,   // Disable phase noise
  input  wire logic               start_jitter_enable, // Start noise enable
  input  wire logic               fast_init_enable,  // Fast init enable
  input  wire logic               measure_mode1,     // Measure mode 1 active
  input  wire logic               irq_flag,          // Converter interrupt flag
  input  wire logic               fire_in,           // Received pulse pin
  input  wire logic [31:0]        cal_raw,           // Calibration count, 16.16
  output logic                    fire_up_o,         // Up driver level
  output logic                    fire_up_oe,        // Up driver enable
  output logic                    fire_down_o,       // Down driver level
  output logic                    fire_down_oe,      // Down driver enable
  output logic                    tdc_start,         // Converter start
  output logic                    tdc_reinit,        // Fast reinit pulse
  output logic [7:0]              start_offset,      // Random start offset
  output ubg_pkg::ubg_fix_t       cal_result,        // Calibration result
  output logic                    busy               // Burst in progress
);
  import ubg_pkg::*;

  ubg_state_t state;
  ubg_count_t pulse_idx;
  logic [2:0] rep_left;
  logic       ref_tick;
  logic       run;
  logic       level;
  logic       phase;
  logic       fin_s1;
  logic       fin_s2;
  logic       fin_prev;
  logic       irq_s1;
  logic       irq_s2;
  logic       irq_prev;
  logic [9:0] quiet_cnt;
  logic [7:0] lfsr;
  logic       drive;
  logic       tail;
  logic       heard;
  logic       flip;

  // The final half pulse keeps the reference divider running
  assign run = (state == UBG_FIRST) || (state == UBG_SECOND) || (state == UBG_WAIT && tail);

  ubg_refclk u_refclk (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .fast_tick (fast_clock_prescale),
    .run       (run),
    .fire_div  (fire_div),
    .ref_tick  (ref_tick)
  );

  // Phase bits only apply for short bursts; noise bit latched at start inverts the first pulse
  always_comb
  begin
    phase = 1'b0;
    if (pulse_count <= `UBG_PHASE_MAX_PULSE) // RULE_06
      phase = pulse_phase_bits[pulse_idx[3:0]]; // RULE_07
    if (flip && pulse_idx == 7'h00) // RULE_15
      phase = ~phase;
  end

  // Pin synchronisers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fin_s1   <= 1'b0;
      fin_s2   <= 1'b0;
      fin_prev <= 1'b0;
      irq_s1   <= 1'b0;
      irq_s2   <= 1'b0;
      irq_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      fin_s1   <= fire_in;
      fin_s2   <= fin_s1;
      fin_prev <= fin_s2;
      irq_s1   <= irq_flag;
      irq_s2   <= irq_s1;
      irq_prev <= irq_s2;
    end
  end

  // Burst sequencer
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state     <= UBG_IDLE;
      pulse_idx <= 7'h00;
      rep_left  <= 3'h0;
      level     <= 1'b0;
      quiet_cnt <= 10'h000;
      tail      <= 1'b0;
      heard     <= 1'b0;
      flip      <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (state)
        UBG_IDLE:
        begin
          level <= 1'b0;
          if (start_cycle && pulse_count != 7'h00) // RULE_08 RULE_05
          begin
            state     <= UBG_FIRST;
            pulse_idx <= 7'h00;
            rep_left  <= repeat_count; // RULE_12
            tail      <= 1'b0;
            heard     <= 1'b0;
            flip      <= !phase_noise_off && lfsr[0]; // RULE_15
          end
        end
        UBG_FIRST:
          if (ref_tick) // RULE_03
          begin
            level <= ~phase;
            state <= UBG_SECOND;
          end
        UBG_SECOND:
          if (ref_tick) // RULE_03
          begin
            level <= phase;
            if (pulse_idx == pulse_count - 7'h01) // RULE_04
            begin
              state     <= UBG_WAIT;
              quiet_cnt <= 10'h000;
              tail      <= 1'b1;
              heard     <= 1'b0;
            end
            else
            begin
              pulse_idx <= pulse_idx + 7'h01;
              state     <= UBG_FIRST;
            end
          end
        UBG_WAIT:
        begin
          if (tail)
          begin
            // Last half of the final pulse keeps its full reference period
            quiet_cnt <= 10'h000;
            if (ref_tick) // RULE_03
            begin
              tail  <= 1'b0;
              level <= 1'b0; // RULE_21
            end
          end
          else
          begin
            // Synchronised echo pulses (fin_s2) are forwarded, 4 cycles after fire_in, while repeats remain
            level <= (rep_left != 3'h0) ? fin_s2 : 1'b0; // RULE_14
            if (fin_s2 != fin_prev)
            begin
              quiet_cnt <= 10'h000;
              heard     <= 1'b1;
            end
            else if (quiet_cnt == 10'(`UBG_QUIET_CYCLES - 1)) // RULE_13
            begin
              quiet_cnt <= 10'h000;
              heard     <= 1'b0;
              // Only a heard sequence counts as a repeat; silence alone rearms the timer unless no repeats remain
              if (rep_left == 3'h0 || (heard && rep_left == 3'h1))
                state <= UBG_IDLE; // RULE_21
              else if (heard)
                rep_left <= rep_left - 3'h1; // RULE_12
            end
            else
              quiet_cnt <= quiet_cnt + 10'h001;
          end
        end
      endcase
    end
  end

  // Drivers active from the first half pulse through the final half and any forwarded repeats
  assign drive = (state == UBG_SECOND) || (state == UBG_FIRST && pulse_idx != 7'h00) ||
                 (state == UBG_WAIT && (tail || rep_left != 3'h0));

  // Output drivers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fire_up_o    <= 1'b0;
      fire_up_oe   <= 1'b0;
      fire_down_o  <= 1'b0;
      fire_down_oe <= 1'b0;
      tdc_start    <= 1'b0;
      busy         <= 1'b0;
    end
    else if (clk_en)
    begin
      busy <= state != UBG_IDLE;
      fire_up_o   <= drive ? level : 1'b0; // RULE_14
      fire_down_o <= drive ? (level ^ driver_config[`UBG_CFG_INVDOWN]) : 1'b0; // RULE_11
      fire_up_oe   <= driver_config[`UBG_CFG_ENUP] && (drive || idle_level_select); // RULE_10 RULE_21
      fire_down_oe <= driver_config[`UBG_CFG_ENDOWN] && (drive || idle_level_select); // RULE_10 RULE_11
      tdc_start    <= fire_as_start && drive && level; // RULE_09
    end
  end

  // Fast reinit and noise generator
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tdc_reinit   <= 1'b0;
      lfsr         <= `UBG_LFSR_SEED;
      start_offset <= 8'h00;
      cal_result   <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      tdc_reinit   <= fast_init_enable && measure_mode1 && irq_s2 && !irq_prev; // RULE_16
      lfsr         <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      start_offset <= start_jitter_enable ? lfsr : 8'h00; // RULE_17
      cal_result   <= cal_raw; // RULE_20
    end
  end

  sequence start_seen_s;
    clk_en && start_cycle && pulse_count != 7'h00 && state == UBG_IDLE;
  endsequence

  burst_start_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_08
    start_seen_s |=> state == UBG_FIRST) else $error("burst did not start");
  tail_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_03
    clk_en && state == UBG_WAIT && tail && !ref_tick |=> tail && level == $past(level))
    else $error("final half pulse cut short");
  zero_count_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_05
    clk_en && state == UBG_IDLE && pulse_count == 7'h00 |=> state == UBG_IDLE) else $error("zero count fired");
  pulse_limit_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_04
    state != UBG_IDLE |-> pulse_idx < pulse_count) else $error("pulse index overran");
  half_tick_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_03
    clk_en && state == UBG_FIRST && !ref_tick |=> state == UBG_FIRST) else $error("phase ended early");
  idle_oe_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_10
    clk_en && state == UBG_IDLE && $past(state) == UBG_IDLE && !idle_level_select |=> !fire_up_oe && !fire_down_oe)
    else $error("idle driver not high-Z");
  idle_gnd_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_21
    clk_en && state == UBG_IDLE |=> !fire_up_o && !fire_down_o) else $error("idle level not low");
  fire_start_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_09
    tdc_start |-> fire_up_o) else $error("start without fire");
  reinit_edge_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_16
    tdc_reinit |-> $past(fast_init_enable) && $past(measure_mode1)) else $error("reinit when disabled");
  jitter_off_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_17
    clk_en && !start_jitter_enable |=> start_offset == 8'h00) else $error("offset without jitter");
  cal_pass_a: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_20
    clk_en |=> cal_result == $past(cal_raw)) else $error("calibration result wrong");
endmodule : ubg_core

// ---- tb/ubg_xducer.sv ----
`timescale 1ns/1ns
module ubg_xducer (
  input  wire logic mclk,    // System clock
  input  wire logic reset_n, // Async reset, active low
  input  wire logic tx_o,    // Up driver level
  input  wire logic tx_oe,   // Up driver enable
  input  wire logic slow,    // Long acoustic path
  output logic      rx_out   // Received echo
);
  logic [699:0] line_q;

  // Flight path as a shift line; an undriven transducer reads as silence
  // Both paths outlast the 5 us quiet time, so each echo is a sequence of its own
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      line_q <= '0;
    else
      line_q <= {line_q[698:0], tx_o & tx_oe};

  assign rx_out = slow ? line_q[699] : line_q[599];
endmodule : ubg_xducer

// ---- tb/test_ultrasonic_burst_generator.sv ----
`timescale 1ns/1ns
module test_ultrasonic_burst_generator;
  import ubg_pkg::*;
  logic       mclk, reset_n, clk_en, fast_clock_prescale, start_cycle, idle_level_select, fire_as_start;
  logic       phase_noise_off, start_jitter_enable, fast_init_enable, measure_mode1, irq_flag, fire_in, slow;
  logic       fire_up_o, fire_up_oe, fire_down_o, fire_down_oe, tdc_start, tdc_reinit, busy;
  ubg_count_t pulse_count;
  logic [3:0] fire_div;
  logic [15:0] pulse_phase_bits;
  logic [2:0] driver_config, repeat_count;
  logic [31:0] cal_raw;
  logic [7:0] start_offset;
  ubg_fix_t   cal_result;
  int         n_fail = 0;
  int         tests_run = 0;
  int         cyc = 0;

  ubg_core u_ubg_core (.mclk, .reset_n, .clk_en, .fast_clock_prescale, .start_cycle, .pulse_count, .fire_div,
    .pulse_phase_bits, .driver_config, .idle_level_select, .fire_as_start, .repeat_count, .phase_noise_off,
    .start_jitter_enable, .fast_init_enable, .measure_mode1, .irq_flag, .fire_in, .cal_raw, .fire_up_o,
    .fire_up_oe, .fire_down_o, .fire_down_oe, .tdc_start, .tdc_reinit, .start_offset, .cal_result, .busy);

  ubg_xducer u_ubg_xducer (.mclk, .reset_n, .tx_o(fire_up_o), .tx_oe(fire_up_oe), .slow, .rx_out(fire_in));

  initial
  begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end

  // Prescaled tick every second cycle
  always @(negedge mclk)
    fast_clock_prescale <= (fast_clock_prescale !== 1'b1);

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic burst(input ubg_count_t n, input logic [15:0] ph, input logic [3:0] dv,
                       input logic [2:0] cfg, input logic [2:0] rep, input logic fs);
    int i, k, h, ups, hi, st, gap;
    logic drv, ex, up, pv;
    h = dv + 1;
    {k, ups, hi, st, gap, pv} = '0;
    @(negedge mclk);
    {pulse_count, pulse_phase_bits, driver_config, repeat_count, fire_as_start} = {n, ph, cfg, rep, fs};
    fire_div = dv;
    start_cycle = 1;
    for (i = 0; i < 9000 && (i < 3 || busy === 1'b1); i++)
    begin
      @(negedge mclk);
      start_cycle = (i == 10) && (n > 5);
      drv = cfg[1] ? fire_up_oe : fire_down_oe;
      if (drv === 1'b1)
      begin
        ex = (k < 2 * n * h) && (ph[(k / (2 * h)) % 16] ^ ((k / h) % 2 == 0));
        if (rep == 0 && cfg[1])
          chk(fire_up_o, ex);
        if (rep == 0 && cfg[0])
          chk(fire_down_o, ex ^ cfg[2]);
        k++;
      end
      if (!cfg[1])
        chk(fire_up_oe, 0);
      up = (fire_up_o & fire_up_oe) === 1'b1;
      ups += up & !pv;
      hi += up;
      st += (tdc_start === 1'b1);
      gap = (up != pv) ? 0 : gap + 1;
      pv = up;
    end
    start_cycle = 0;
    chk(busy, 0);
    chk(n == 0 ? k == 0 : k >= 2 * n * h, 1);
    if (ph == 0 && cfg[1])
      chk(ups, n * (rep + 1));
    chk(st, fs ? hi : 0);
    if (rep != 0)
      chk(gap >= 500, 1);
    chk(fire_up_oe | fire_down_oe, 0);
    // Let the flight path empty so no stale echo reaches the next burst
    repeat (800) @(negedge mclk);
  endtask : burst

  task automatic noise;
    int i, j, hi;
    phase_noise_off = 0;
    for (j = 0; j < 3; j++)
    begin
      hi = 0;
      @(negedge mclk);
      {pulse_count, pulse_phase_bits, driver_config, repeat_count, fire_div} = {7'h01, 16'h0000, 3'h2, 3'h0, 4'h1};
      start_cycle = 1;
      for (i = 0; i < 1000 && (i < 3 || busy === 1'b1); i++)
      begin
        @(negedge mclk);
        start_cycle = 0;
        hi += ((fire_up_o & fire_up_oe) === 1'b1);
      end
      chk(hi, 2);
      repeat (800) @(negedge mclk);
    end
    phase_noise_off = 1;
  endtask : noise

  task automatic idle_gnd;
    @(negedge mclk);
    driver_config = 3'h3;
    idle_level_select = 1;
    repeat (3) @(negedge mclk);
    chk({fire_up_oe, fire_up_o, fire_down_oe, fire_down_o}, 4'ha);
    idle_level_select = 0;
  endtask : idle_gnd

  task automatic fast_init(input logic en);
    int i, c;
    c = 0;
    @(negedge mclk);
    {fast_init_enable, measure_mode1, irq_flag} = {en, 2'h3};
    for (i = 0; i < 20; i++)
    begin
      @(negedge mclk);
      c += (tdc_reinit === 1'b1);
    end
    irq_flag = 0;
    chk(c, en);
  endtask : fast_init

  task automatic misc;
    int i, c;
    c = 0;
    @(negedge mclk);
    cal_raw = 32'h01e5d700;
    fire_as_start = 1;
    start_jitter_enable = 1;
    for (i = 0; i < 20; i++)
    begin
      @(negedge mclk);
      c += (start_offset !== 8'h00);
    end
    chk(cal_result, 32'h01e5d700);
    chk(c != 0, 1);
    clk_en = 0;
    cal_raw = 32'h0000_0000;
    repeat (3) @(negedge mclk);
    chk(cal_result, 32'h01e5d700);
    clk_en = 1;
    cal_raw = 32'h01e5d700;
    fire_as_start = 0;
  endtask : misc

  task automatic complete_run;
    $display("fails=%0d tests=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  initial
  begin
    {reset_n, start_cycle, idle_level_select, fire_as_start, start_jitter_enable} = '0;
    {fast_init_enable, measure_mode1, irq_flag, slow, pulse_count, pulse_phase_bits} = '0;
    {driver_config, repeat_count, cal_raw} = '0;
    {clk_en, phase_noise_off} = 2'h3;
    fire_div = 4'h1;
    repeat (8) @(negedge mclk);
    reset_n = 1;
    burst(7, 16'h0055, 3, 3'h3, 0, 0);
    burst(15, 16'h7a3c, 1, 3'h7, 0, 1);
    burst(1, 16'h0001, 15, 3'h1, 0, 0);
    burst(0, 16'h0000, 3, 3'h3, 0, 1);
    burst(127, 16'h0000, 1, 3'h2, 0, 1);
    burst(3, 16'h0000, 3, 3'h2, 1, 0);
    slow = 1;
    burst(3, 16'h0000, 3, 3'h2, 7, 0);
    noise;
    idle_gnd;
    fast_init(1);
    fast_init(0);
    misc;
    complete_run;
  end
endmodule : test_ultrasonic_burst_generator
